// >>> rtl/fsp_regs.vh
// constants for the flash status and protection block
`ifndef FSP_REGS_VH
`define FSP_REGS_VH
// ========================================
// command codes
`define FSP_OP_WRITE_UNLOCK 8'h06
`define FSP_OP_WRITE_LOCK 8'h04
`define FSP_OP_READ_LOW 8'h05
`define FSP_OP_READ_HIGH 8'h35
`define FSP_OP_STATUS_WRITE 8'h01
`define FSP_OP_PAGE_WRITE 8'h02
`define FSP_OP_UNIT4K_CLEAR 8'h20
`define FSP_OP_BLOCK32_CLEAR 8'h52
`define FSP_OP_BLOCK64_CLEAR 8'hD8
`define FSP_OP_CHIP_CLEAR_A 8'h60
`define FSP_OP_CHIP_CLEAR_B 8'hC7
`define FSP_OP_SUSPEND 8'h75
`define FSP_OP_RESUME 8'h7A
`define FSP_OP_RESET_ARM 8'h66
`define FSP_OP_RESET_GO 8'h99
// ========================================
// status bit positions (16-bit view, high byte bits 15..8)
`define FSP_BIT_BUSY 0
`define FSP_BIT_WUL 1
`define FSP_BIT_AREA_LO 2
`define FSP_BIT_AREA_HI 6
`define FSP_BIT_GUARD_LO 7
`define FSP_BIT_GUARD_HI 8
`define FSP_BIT_QUAD 9
`define FSP_BIT_WPAUSE 10
`define FSP_BIT_OTP_LO 11
`define FSP_BIT_OTP_HI 13
`define FSP_BIT_INVERT 14
`define FSP_BIT_CPAUSE 15
// ========================================
// reset values of the stored bits
`define FSP_RST_AREA 5'h0
`define FSP_RST_GUARD 2'h0
`define FSP_RST_QUAD 1'b0
`define FSP_RST_OTP 3'h0
`define FSP_RST_INVERT 1'b0
// ========================================
// timing counts in clk_sys cycles
`define FSP_PROG_CYCLES 16'h0100
`define FSP_CLEAR_CYCLES 16'h0400
`define FSP_SRW_CYCLES 16'h0040
`endif

// >>> rtl/fsp_status_regs.v
// flash status registers, command decode and write protection
`timescale 1ns/100ps
`include "fsp_regs.vh"
module fsp_status_regs #(
	parameter [15:0] PROG_CYCLES = `FSP_PROG_CYCLES,
	parameter [15:0] CLEAR_CYCLES = `FSP_CLEAR_CYCLES,
	parameter [15:0] SRW_CYCLES = `FSP_SRW_CYCLES
) (
	// clock and power-up reset
	input wire clk_sys,
	input wire rst_n,
	// serial link pins
	input wire sclk,
	input wire cs_n,
	input wire si,
	output reg so,
	output reg so_oe,
	// protect pin, data line two when quad is on
	input wire io2_in,
	output wire io2_out,
	output wire io2_oe,
	// pause pin, data line three when quad is on
	input wire io3_in,
	output wire io3_out,
	output wire io3_oe,
	// guarded-area decoder outside this block
	output reg [23:0] target_addr,
	output wire [4:0] area_guard,
	output wire invert_guard_bit,
	input wire target_guarded,
	// array engine requests
	output reg page_write_start,
	output reg clear_start,
	output reg [1:0] clear_kind,
	// mode outputs
	output wire quad_lines_on,
	output wire [2:0] otp_lock
);
	// ========================================
	// pin synchronisers
	wire sclk_s, cs_n_s, si_s, wp_s, hold_s;
	fsp_sync2 #(.WIDTH(5), .INIT(5'h0B)) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d({sclk, cs_n, si, io2_in, io3_in}),
		.q({sclk_s, cs_n_s, si_s, wp_s, hold_s})
	);
	reg sclk_d, cs_d;
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_d <= cs_n_s;
		end
	end

	// ========================================
	// status storage
	reg busy_flag, write_unlock_latch;
	reg [4:0] area_q;
	reg status_guard_lo, status_guard_hi;
	reg quad_q, invert_q;
	reg otp_lock_a, otp_lock_b, otp_lock_c;
	reg clear_paused_flag, write_paused_flag;
	assign area_guard = area_q;
	assign invert_guard_bit = invert_q;
	assign quad_lines_on = quad_q;
	assign otp_lock = {otp_lock_c, otp_lock_b, otp_lock_a};
	// pins stay inputs: quad data path lives elsewhere
	assign io2_out = 1'b0;
	assign io2_oe = 1'b0;
	assign io3_out = 1'b0;
	assign io3_oe = 1'b0;
	wire [7:0] stat_lo = {status_guard_lo, area_q, write_unlock_latch, busy_flag};
	wire [7:0] stat_hi = {clear_paused_flag, invert_q, otp_lock_c, otp_lock_b, otp_lock_a,
		write_paused_flag, quad_q, status_guard_hi};

	// ========================================
	// protection decisions
	// pause starts and ends while the link clock is low; quad on ends it at any time
	reg hold_act;
	always @(posedge clk_sys) begin
		if (!rst_n || quad_q) begin
			hold_act <= 1'b0;
		end else if (!sclk_s) begin
			hold_act <= !hold_s;
		end
	end
	wire wp_level = quad_q ? 1'b1 : wp_s;
	wire [1:0] guard = {status_guard_hi, status_guard_lo};
	reg status_open;
	always @* begin
		status_open = 1'b0;
		if (guard == 2'b00) begin
			status_open = 1'b1;
		end else if (guard == 2'b01) begin
			status_open = wp_level;
		end else begin
			status_open = 1'b0;
		end
	end
	wire chip_ok = (area_q[2:0] == 3'b000 && !invert_q) ||
		(area_q[2:0] == 3'b111 && invert_q);

	// ========================================
	// serial shift-in
	wire rise = sclk_s && !sclk_d && !cs_n_s && !hold_act;
	wire fall = !sclk_s && sclk_d && !cs_n_s && !hold_act;
	wire cs_rise = cs_n_s && !cs_d;
	reg [7:0] shin, opcode, data_lo, data_hi;
	reg [2:0] bit_cnt;
	reg [2:0] byte_cnt;
	reg reset_armed;
	wire [7:0] next_shin = {shin[6:0], si_s};
	always @(posedge clk_sys) begin
		if (!rst_n || cs_rise) begin
			shin <= 8'h00;
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
		end else if (rise) begin
			shin <= next_shin;
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7 && byte_cnt != 3'h7) begin
				byte_cnt <= byte_cnt + 3'h1;
			end
		end
	end
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			opcode <= 8'h00;
			data_lo <= 8'h00;
			data_hi <= 8'h00;
			target_addr <= 24'h00_0000;
		end else if (rise && bit_cnt == 3'h7) begin
			if (byte_cnt == 3'h0) begin
				opcode <= next_shin;
			end else if (byte_cnt == 3'h1) begin
				data_lo <= next_shin;
				target_addr[23:16] <= next_shin;
			end else if (byte_cnt == 3'h2) begin
				data_hi <= next_shin;
				target_addr[15:8] <= next_shin;
			end else if (byte_cnt == 3'h3) begin
				target_addr[7:0] <= next_shin;
			end
		end
	end

	// ========================================
	// status read-out on falling edges
	reg [7:0] shout;
	reg [2:0] out_cnt;
	reg rd_high;
	reg rd_on;
	always @(posedge clk_sys) begin
		if (!rst_n || cs_rise) begin
			so <= 1'b0;
			rd_on <= 1'b0;
			shout <= 8'h00;
			out_cnt <= 3'h0;
			rd_high <= 1'b0;
		end else if (rise && bit_cnt == 3'h7 && byte_cnt == 3'h0) begin
			if (next_shin == `FSP_OP_READ_LOW || next_shin == `FSP_OP_READ_HIGH) begin
				rd_on <= 1'b1;
				rd_high <= (next_shin == `FSP_OP_READ_HIGH);
				shout <= (next_shin == `FSP_OP_READ_HIGH) ? stat_hi : stat_lo;
				out_cnt <= 3'h0;
			end
		end else if (fall && rd_on) begin
			so <= shout[7];
			out_cnt <= out_cnt + 3'h1;
			if (out_cnt == 3'h7) begin
				shout <= rd_high ? stat_hi : stat_lo;
			end else begin
				shout <= {shout[6:0], 1'b0};
			end
		end
	end

	// output let go while a pause is in force
	always @(posedge clk_sys) begin
		if (!rst_n || cs_rise) begin
			so_oe <= 1'b0;
		end else begin
			so_oe <= rd_on && !hold_act;
		end
	end

	// ========================================
	// command execution at chip select release
	localparam ST_IDLE = 2'd0;
	localparam ST_PROG = 2'd1;
	localparam ST_CLEAR = 2'd2;
	localparam ST_SRW = 2'd3;
	reg [1:0] state, saved_state;
	reg [15:0] busy_cnt;
	wire framed = (bit_cnt == 3'h0) && (byte_cnt != 3'h0);
	wire is_clear = opcode == `FSP_OP_UNIT4K_CLEAR || opcode == `FSP_OP_BLOCK32_CLEAR ||
		opcode == `FSP_OP_BLOCK64_CLEAR;
	wire is_chip = opcode == `FSP_OP_CHIP_CLEAR_A || opcode == `FSP_OP_CHIP_CLEAR_B;
	wire paused = clear_paused_flag || write_paused_flag;
	// suspend only while an array operation still has cycles left
	wire susp_ok = (state == ST_PROG || state == ST_CLEAR) && busy_cnt != 16'h0001;
	// write-type requests before the guard checks
	wire srw_req = opcode == `FSP_OP_STATUS_WRITE && write_unlock_latch &&
		byte_cnt >= 3'h2 && !paused;
	wire pw_req = opcode == `FSP_OP_PAGE_WRITE && write_unlock_latch &&
		byte_cnt >= 3'h5 && !write_paused_flag;
	wire clr_req = is_clear && write_unlock_latch && byte_cnt == 3'h4 && !paused;
	wire chip_req = is_chip && write_unlock_latch && byte_cnt == 3'h1 && !paused;
	// size code handed to the clear engine
	reg [1:0] clear_code;
	always @* begin
		if (opcode == `FSP_OP_UNIT4K_CLEAR) begin
			clear_code = 2'd0;
		end else if (opcode == `FSP_OP_BLOCK32_CLEAR) begin
			clear_code = 2'd1;
		end else begin
			clear_code = 2'd2;
		end
	end
	// select released in a pause clears the frame without acting
	wire exec = cs_rise && framed && !hold_act;
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			saved_state <= ST_IDLE;
			busy_cnt <= 16'h0000;
			busy_flag <= 1'b0;
			write_unlock_latch <= 1'b0;
			area_q <= `FSP_RST_AREA;
			{status_guard_hi, status_guard_lo} <= `FSP_RST_GUARD;
			quad_q <= `FSP_RST_QUAD;
			invert_q <= `FSP_RST_INVERT;
			{otp_lock_c, otp_lock_b, otp_lock_a} <= `FSP_RST_OTP;
			clear_paused_flag <= 1'b0;
			write_paused_flag <= 1'b0;
			reset_armed <= 1'b0;
			page_write_start <= 1'b0;
			clear_start <= 1'b0;
			clear_kind <= 2'd0;
		end else begin
			page_write_start <= 1'b0;
			clear_start <= 1'b0;
			if (state != ST_IDLE) begin
				if (busy_cnt == 16'h0001) begin
					state <= ST_IDLE;
					busy_flag <= 1'b0;
				end
				busy_cnt <= busy_cnt - 16'h0001;
			end
			if (exec) begin
				reset_armed <= (opcode == `FSP_OP_RESET_ARM);
				if (opcode == `FSP_OP_RESET_GO && reset_armed) begin
					state <= ST_IDLE;
					busy_flag <= 1'b0;
					write_unlock_latch <= 1'b0;
					clear_paused_flag <= 1'b0;
					write_paused_flag <= 1'b0;
				end else if (opcode == `FSP_OP_SUSPEND && susp_ok) begin
					saved_state <= state;
					state <= ST_IDLE;
					busy_flag <= 1'b0;
					clear_paused_flag <= (state == ST_CLEAR);
					write_paused_flag <= (state == ST_PROG);
				end else if (opcode == `FSP_OP_RESUME && paused && state == ST_IDLE) begin
					state <= saved_state;
					busy_flag <= 1'b1;
					clear_paused_flag <= 1'b0;
					write_paused_flag <= 1'b0;
				end else if (state == ST_IDLE) begin
					if (opcode == `FSP_OP_WRITE_UNLOCK) begin
						write_unlock_latch <= 1'b1;
					end else if (opcode == `FSP_OP_WRITE_LOCK) begin
						write_unlock_latch <= 1'b0;
					end else if (srw_req) begin
						write_unlock_latch <= 1'b0;
						if (status_open) begin
							// busy, latch and paused flags ignore written data
							area_q <= data_lo[`FSP_BIT_AREA_HI:`FSP_BIT_AREA_LO];
							status_guard_lo <= data_lo[`FSP_BIT_GUARD_LO];
							if (byte_cnt >= 3'h3) begin
								status_guard_hi <= data_hi[`FSP_BIT_GUARD_HI - 8];
								quad_q <= data_hi[`FSP_BIT_QUAD - 8];
								invert_q <= data_hi[`FSP_BIT_INVERT - 8];
								otp_lock_a <= otp_lock_a | data_hi[`FSP_BIT_OTP_LO - 8];
								otp_lock_b <= otp_lock_b | data_hi[`FSP_BIT_OTP_LO - 7];
								otp_lock_c <= otp_lock_c | data_hi[`FSP_BIT_OTP_HI - 8];
							end
							state <= ST_SRW;
							busy_cnt <= SRW_CYCLES;
							busy_flag <= 1'b1;
						end
					end else if (pw_req) begin
						write_unlock_latch <= 1'b0;
						if (!target_guarded) begin
							page_write_start <= 1'b1;
							state <= ST_PROG;
							busy_cnt <= PROG_CYCLES;
							busy_flag <= 1'b1;
						end
					end else if (clr_req) begin
						write_unlock_latch <= 1'b0;
						if (!target_guarded) begin
							clear_start <= 1'b1;
							clear_kind <= clear_code;
							state <= ST_CLEAR;
							busy_cnt <= CLEAR_CYCLES;
							busy_flag <= 1'b1;
						end
					end else if (chip_req) begin
						write_unlock_latch <= 1'b0;
						if (chip_ok) begin
							clear_start <= 1'b1;
							clear_kind <= 2'd3;
							state <= ST_CLEAR;
							busy_cnt <= CLEAR_CYCLES;
							busy_flag <= 1'b1;
						end
					end
				end
			end
		end
	end
endmodule

// >>> rtl/fsp_sync2.v
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module fsp_sync2 #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// data
	input wire [WIDTH-1:0] d,
	output reg [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta;
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			meta <= INIT;
			q <= INIT;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// >>> testbench/fsp_host.sv
// host serial controller model
`timescale 1ns/100ps
module fsp_host (
	// clock
	input wire clk_sys,
	// serial link
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire so
);
	initial begin
		sclk = 0;
		cs_n = 1;
		si = 0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic bit_io(input logic b, output logic r);
		si = b;
		tick(4);
		sclk = 1;
		tick(4);
		r = so;
		sclk = 0;
	endtask
	task automatic byte_io(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r[i]);
	endtask
	task automatic sel;
		cs_n = 0;
		tick(4);
	endtask
	// data line no longer held once deselected
	task automatic desel;
		tick(4);
		cs_n = 1;
		si = ~si;
		tick(12);
	endtask
endmodule

// >>> testbench/fsp_status_regs_chk.sv
// port assertions for the flash status block
`timescale 1ns/100ps
module fsp_status_regs_chk (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// link and pins
	input wire cs_n,
	input wire so_oe,
	input wire io2_oe,
	input wire io3_oe,
	// status and array requests
	input wire target_guarded,
	input wire [4:0] area_guard,
	input wire invert_guard_bit,
	input wire page_write_start,
	input wire clear_start,
	input wire [1:0] clear_kind,
	input wire quad_lines_on,
	input wire [2:0] otp_lock
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// frame closed: select high now and two edges back
	sequence s_desel;
		cs_n && $past(cs_n, 2);
	endsequence
	sequence s_drop;
		##1 !clear_start;
	endsequence
	property p_otp_keep;
		(otp_lock & $past(otp_lock)) == $past(otp_lock);
	endproperty
	a_otp_keep: assert property (p_otp_keep) else $error("lock bit fell");
	property p_quad_pins;
		!quad_lines_on |-> !io2_oe && !io3_oe;
	endproperty
	a_quad_pins: assert property (p_quad_pins) else $error("pin driven");
	property p_area_src;
		$changed(area_guard) |-> s_desel;
	endproperty
	a_area_src: assert property (p_area_src) else $error("area changed in frame");
	property p_pw_src;
		page_write_start |-> s_desel;
	endproperty
	a_pw_src: assert property (p_pw_src) else $error("program in frame");
	property p_clr_pulse;
		clear_start |-> s_drop;
	endproperty
	a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse long");
	property p_unguarded;
		page_write_start || clear_start && clear_kind != 2'h3 |-> !$past(target_guarded);
	endproperty
	a_unguarded: assert property (p_unguarded) else $error("guarded start");
	property p_chip_ok;
		clear_start && clear_kind == 2'h3 |->
			(invert_guard_bit ? area_guard[2:0] == 3'h7 : area_guard[2:0] == 3'h0);
	endproperty
	a_chip_ok: assert property (p_chip_ok) else $error("chip clear guarded");
	property p_oe_sel;
		$rose(so_oe) |-> !cs_n;
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("output unselected");
endmodule
bind fsp_status_regs fsp_status_regs_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.cs_n(cs_n), .so_oe(so_oe), .io2_oe(io2_oe), .io3_oe(io3_oe),
	.target_guarded(target_guarded), .area_guard(area_guard),
	.invert_guard_bit(invert_guard_bit), .page_write_start(page_write_start),
	.clear_start(clear_start), .clear_kind(clear_kind), .quad_lines_on(quad_lines_on),
	.otp_lock(otp_lock));

// >>> testbench/fsp_status_regs_test.sv
// self-checking bench for the flash status block
`timescale 1ns/100ps
module fsp_status_regs_test;
	logic clk_sys = 0;
	logic rst_n = 0;
	logic io2_in = 1;
	logic io3_in = 1;
	logic tg = 0;
	logic [7:0] n_pw = 0;
	logic [7:0] n_clr = 0;
	int mismatches = 0;
	int checks_done = 0;
	int cyc = 0;
	wire sclk, cs_n, si, so, inv, quad, pws, clr;
	wire [4:0] area;
	wire [2:0] otp;
	wire [23:0] ta;
	wire [1:0] ck;
	fsp_host h (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
	fsp_status_regs #(.PROG_CYCLES(16'h012c), .CLEAR_CYCLES(16'h0190), .SRW_CYCLES(16'h00c8))
	dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(), .io2_in(io2_in), .io2_out(), .io2_oe(), .io3_in(io3_in), .io3_out(),
		.io3_oe(), .target_addr(ta), .area_guard(area), .invert_guard_bit(inv),
		.target_guarded(tg), .page_write_start(pws), .clear_start(clr), .clear_kind(ck),
		.quad_lines_on(quad), .otp_lock(otp));
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		n_pw <= n_pw + {7'h00, pws};
		n_clr <= n_clr + {7'h00, clr};
		if (cyc == 60000) begin
			mismatches++;
			test_done;
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("BAD at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		logic [7:0] r;
		h.sel;
		h.byte_io(op, r);
		h.desel;
	endtask
	task automatic rd(input logic [7:0] op, output logic [7:0] v);
		h.sel;
		h.byte_io(op, v);
		h.byte_io(8'h00, v);
		h.desel;
	endtask
	task automatic rchk(input logic [7:0] op, input logic [7:0] e);
		logic [7:0] v;
		rd(op, v);
		chk(v, e);
	endtask
	task automatic wr(input logic [15:0] v, input logic en);
		logic [7:0] r;
		if (en)
			cmd(8'h06);
		h.sel;
		h.byte_io(8'h01, r);
		h.byte_io(v[7:0], r);
		h.byte_io(v[15:8], r);
		h.desel;
	endtask
	// leaves the frame open for data or release
	task automatic adr(input logic [7:0] op, input logic [23:0] a);
		logic [7:0] r;
		cmd(8'h06);
		h.sel;
		h.byte_io(op, r);
		h.byte_io(a[23:16], r);
		h.byte_io(a[15:8], r);
		h.byte_io(a[7:0], r);
	endtask
	task automatic idle;
		logic [7:0] v;
		for (int i = 0; i < 20; i++) begin
			rd(8'h05, v);
			if (v[0] === 1'b0)
				return;
		end
		chk(v, 8'h00);
	endtask
	task automatic pwr;
		rst_n = 0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1;
		repeat (4) @(negedge clk_sys);
	endtask
	task automatic t_latch;
		logic [7:0] r;
		rchk(8'h35, 8'h00);
		wr(16'h001c, 1'b0);
		rchk(8'h05, 8'h00);
		h.sel;
		h.byte_io(8'h06, r);
		h.bit_io(1'b0, r[0]);
		h.desel;
		rchk(8'h05, 8'h00);
		io3_in = 0;
		cmd(8'h06);
		io3_in = 1;
		rchk(8'h05, 8'h00);
		cmd(8'h06);
		rchk(8'h05, 8'h02);
		cmd(8'h04);
		rchk(8'h05, 8'h00);
		$display("latch test done");
	endtask
	task automatic t_write;
		wr(16'h005f, 1'b1);
		rchk(8'h05, 8'h5d);
		chk({3'h0, area}, 8'h17);
		idle;
		rchk(8'h05, 8'h5c);
		wr(16'h0080, 1'b1);
		idle;
		io2_in = 0;
		wr(16'h009c, 1'b1);
		rchk(8'h05, 8'h80);
		chk({3'h0, area}, 8'h00);
		io2_in = 1;
		wr(16'h0084, 1'b1);
		idle;
		rchk(8'h05, 8'h84);
		wr(16'h0000, 1'b1);
		idle;
		io2_in = 0;
		wr(16'h0004, 1'b1);
		idle;
		rchk(8'h05, 8'h04);
		io2_in = 1;
		$display("write test done");
	endtask
	task automatic t_chip;
		logic [7:0] k;
		k = n_clr;
		wr(16'h401c, 1'b1);
		idle;
		chk({7'h00, inv}, 8'h01);
		cmd(8'h06);
		cmd(8'h60);
		chk(n_clr - k, 8'h01);
		chk({6'h00, ck}, 8'h03);
		idle;
		wr(16'h001c, 1'b1);
		idle;
		cmd(8'h06);
		cmd(8'hc7);
		chk(n_clr - k, 8'h01);
		tg = 1;
		adr(8'h20, 24'h12_3000);
		h.desel;
		chk(ta[23:16], 8'h12);
		chk(n_clr - k, 8'h01);
		rchk(8'h05, 8'h1c);
		tg = 0;
		wr(16'h0000, 1'b1);
		idle;
		$display("chip clear test done");
	endtask
	task automatic t_pause;
		logic [7:0] k;
		logic [7:0] r;
		k = n_pw;
		adr(8'h52, 24'h04_0000);
		h.desel;
		chk({6'h00, ck}, 8'h01);
		cmd(8'h75);
		rchk(8'h35, 8'h80);
		cmd(8'h7a);
		rchk(8'h35, 8'h00);
		idle;
		adr(8'h02, 24'h00_0100);
		h.byte_io(8'ha5, r);
		h.desel;
		chk(n_pw - k, 8'h01);
		chk(ta[15:8], 8'h01);
		cmd(8'h75);
		rchk(8'h35, 8'h04);
		cmd(8'h66);
		cmd(8'h99);
		rchk(8'h35, 8'h00);
		idle;
		$display("suspend test done");
	endtask
	task automatic t_otp;
		wr(16'h0a00, 1'b1);
		idle;
		chk({5'h00, otp}, 8'h01);
		chk({7'h00, quad}, 8'h01);
		io3_in = 0;
		cmd(8'h06);
		io3_in = 1;
		rchk(8'h05, 8'h02);
		wr(16'h0100, 1'b1);
		idle;
		chk({5'h00, otp}, 8'h01);
		chk({7'h00, quad}, 8'h00);
		wr(16'h0004, 1'b1);
		rchk(8'h05, 8'h00);
		pwr;
		rchk(8'h35, 8'h00);
		wr(16'h0004, 1'b1);
		idle;
		rchk(8'h05, 8'h04);
		wr(16'h0180, 1'b1);
		idle;
		wr(16'h0004, 1'b1);
		rchk(8'h05, 8'h80);
		$display("lock test done");
	endtask
	initial begin
		pwr;
		t_latch;
		t_write;
		t_chip;
		t_pause;
		t_otp;
		test_done;
	end
endmodule
